// [hdl/sdwp_pkg.sv]
// shared constants, field layout and mode decoding for the serial converter write port
`default_nettype none
package sdwp_pkg;

  // ==========================================================================
  // word layout
  localparam int WORD_BITS = 16;  // bits in one framed write
  localparam int CODE_BITS = 12;  // converter code width
  localparam int MODE_HI   = 13;  // mode_bit_high position
  localparam int MODE_LO   = 12;  // mode_bit_low position
  localparam logic [4:0] LAST_BIT = 5'h0F;  // count before the 16th edge
  localparam logic [4:0] FULL_CNT = 5'h10;  // bits in a complete word
  localparam logic [4:0] BYTE_CNT = 5'h08;  // bits in one byte

  // ==========================================================================
  // reset values
  localparam logic [11:0] CODE_RESET = 12'h000;  // power-on code, zero volts
  localparam logic [1:0]  MODE_RESET = 2'h0;     // power-on mode, normal

  // ==========================================================================
  // operating mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;  // amplifier drives output
  localparam logic [1:0] MODE_PD_5K  = 2'h1;  // power-down, 5 kohm to ground
  localparam logic [1:0] MODE_PD_100K = 2'h2; // power-down, 100 kohm to ground
  localparam logic [1:0] MODE_PD_HIZ = 2'h3;  // power-down, output floating

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS   = 40;  // pclk period
  localparam int T_SYNC_HIGH_NS  = 37;  // least frame select high time
  localparam int T_SCLK_HALF_NS  = 20;  // least serial clock high or low time
  localparam int SYNC_HIGH_CYC   = ((T_SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                   1 : (T_SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_MIN   = ((T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                   1 : (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYCLES_DEF = 4;   // pclk cycles per serial clock half

  // ==========================================================================
  // host controller register map
  localparam logic [11:0] REG_TX   = 12'h000;  // word to send
  localparam logic [11:0] REG_CTRL = 12'h004;  // framing options
  localparam logic [11:0] REG_STAT = 12'h008;  // busy and sent count
  localparam int CTRL_BYTE_MODE = 0;  // send as two bytes
  localparam int CTRL_LSB_FIRST = 1;  // software word is lsb first
  localparam int CTRL_STOP_LO   = 8;  // early frame end after n bits, 0 off
  localparam int STAT_SENT_LO   = 8;  // completed word counter

  // output stage controls {amp_on, pd_5k, pd_100k, out_hiz} for a mode
  function automatic logic [3:0] mode_flags(input logic [1:0] mode);
    logic [3:0] f;
    f = 4'h0;
    unique case (mode)
      MODE_NORMAL:  f = 4'h8;
      MODE_PD_5K:   f = 4'h4;
      MODE_PD_100K: f = 4'h2;
      MODE_PD_HIZ:  f = 4'h1;
    endcase
    return f;
  endfunction : mode_flags

  // mirror a 16-bit word
  function automatic logic [15:0] bit_rev16(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15 - i];
    end
    return r;
  endfunction : bit_rev16

endpackage : sdwp_pkg
`default_nettype wire

// [hdl/sdwp_link_if.sv]
// three-wire serial write link between host controller and converter
`default_nettype none
interface sdwp_link_if;
  logic sclk;    // serial clock, made by the host
  logic sync_n;  // frame select, active low
  logic din;     // serial data, msb first

  modport host (output sclk, output sync_n, output din);
  modport dac  (input sclk, input sync_n, input din);
endinterface : sdwp_link_if
`default_nettype wire

// [hdl/sdwp_device.sv]
// converter end of the link: pin sampling, input shift register, mode and code
`default_nettype none

module sdwp_device (
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // asynchronous reset, active low
  sdwp_link_if.dac         link,     // serial write link
  output logic [11:0]      dac_code, // converter register
  output logic [1:0]       op_mode,  // active operating mode
  output logic             amp_on,   // output amplifier driving
  output logic             pd_5k,    // 5 kohm pull-down on
  output logic             pd_100k,  // 100 kohm pull-down on
  output logic             out_hiz,  // output floating
  output logic             update,   // one-cycle pulse on a completed word
  output logic             aborted   // one-cycle pulse on an invalid frame
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0]  sclk_s;   // serial clock synchroniser plus edge stage
    logic [1:0]  sync_s;   // frame select synchroniser
    logic [1:0]  din_s;    // data synchroniser
    logic [15:0] shreg;    // serial_input_word
    logic [4:0]  cnt;      // bits taken in this frame
    logic        done;     // word complete, wait for frame rise
    logic [11:0] code;     // converter register
    logic [1:0]  mode;     // operating mode
    logic        amp_on;
    logic        pd_5k;
    logic        pd_100k;
    logic        hiz;
    logic        update;
    logic        aborted;
  } sdwp_dev_t;

  sdwp_dev_t s_reg;
  sdwp_dev_t s_next;

  logic        sclk_fall;  // falling serial clock edge seen
  logic [15:0] word;       // shift register after this bit
  logic [3:0]  flags;      // output stage controls of the new mode

  // ==========================================================================
  // next state
  always_comb begin
    s_next  = s_reg;
    word    = {s_reg.shreg[14:0], s_reg.din_s[1]};
    flags   = sdwp_pkg::mode_flags(word[sdwp_pkg::MODE_HI:sdwp_pkg::MODE_LO]);
    s_next.update  = 1'b0;
    s_next.aborted = 1'b0;

    // every pin passes two flops; the edge test reads stages two and three only
    s_next.sclk_s = {s_reg.sclk_s[1:0], link.sclk};
    s_next.sync_s = {s_reg.sync_s[0], link.sync_n};
    s_next.din_s  = {s_reg.din_s[0], link.din};
    sclk_fall     = s_reg.sclk_s[2] & ~s_reg.sclk_s[1];

    if (s_reg.sync_s[1]) begin
      // frame high: any partial word is thrown away and a new frame can begin
      if ((s_reg.cnt != 5'h00) && !s_reg.done) begin
        s_next.aborted = 1'b1;
      end
      s_next.shreg = 16'h0000;
      s_next.cnt   = 5'h00;
      s_next.done  = 1'b0;
    end else if (sclk_fall && !s_reg.done) begin
      // frame low: data bits come in msb first on falling edges
      s_next.shreg = word;
      s_next.cnt   = s_reg.cnt + 5'h01;
      if (s_reg.cnt == sdwp_pkg::LAST_BIT) begin
        // the last bit and the update land on the same edge, no latency
        s_next.done   = 1'b1;
        s_next.update = 1'b1;
        s_next.mode   = word[sdwp_pkg::MODE_HI:sdwp_pkg::MODE_LO];
        s_next.code   = word[sdwp_pkg::CODE_BITS-1:0];
        s_next.amp_on  = flags[3];
        s_next.pd_5k   = flags[2];
        s_next.pd_100k = flags[1];
        s_next.hiz     = flags[0];
      end
    end
    // extra edges after a complete word are ignored until frame select rises;
    // code, mode and output stage are touched only above, so a cut frame
    // leaves them exactly as they were
  end

  // ==========================================================================
  // registers; reset stands in for power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.sclk_s  <= 3'h0;
      s_reg.sync_s  <= 2'h3;
      s_reg.din_s   <= 2'h0;
      s_reg.shreg   <= 16'h0000;
      s_reg.cnt     <= 5'h00;
      s_reg.done    <= 1'b0;
      s_reg.code    <= sdwp_pkg::CODE_RESET;
      s_reg.mode    <= sdwp_pkg::MODE_RESET;
      s_reg.amp_on  <= 1'b1;
      s_reg.pd_5k   <= 1'b0;
      s_reg.pd_100k <= 1'b0;
      s_reg.hiz     <= 1'b0;
      s_reg.update  <= 1'b0;
      s_reg.aborted <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs straight from the state flops
  assign dac_code = s_reg.code;
  assign op_mode  = s_reg.mode;
  assign amp_on   = s_reg.amp_on;
  assign pd_5k    = s_reg.pd_5k;
  assign pd_100k  = s_reg.pd_100k;
  assign out_hiz  = s_reg.hiz;
  assign update   = s_reg.update;
  assign aborted  = s_reg.aborted;

endmodule : sdwp_device
`default_nettype wire

// [hdl/sdwp_host.sv]
// host end of the link: apb registers, serial clock divider, frame sequencer
`default_nettype none

// ============================================================================
module sdwp_host #(
  parameter int HALF_CYCLES = sdwp_pkg::HALF_CYCLES_DEF  // pclk cycles per sclk half
) (
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // asynchronous reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction, high write
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic [31:0]      prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  sdwp_link_if.host        link      // serial write link
);

  // hold lasts at least a serial half and the least frame high time
  localparam int HOLD_CYC = (HALF_CYCLES > sdwp_pkg::SYNC_HIGH_CYC) ?
                            HALF_CYCLES : sdwp_pkg::SYNC_HIGH_CYC;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);

  // ==========================================================================
  // state
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_GAP, H_HOLD} sdwp_hst_t;

  typedef struct packed {
    sdwp_hst_t   st;
    logic [7:0]  div;
    logic [4:0]  bits;      // falling edges made in this frame
    logic [15:0] shreg;
    logic [15:0] txword;
    logic        byte_mode;
    logic        lsb_first;
    logic [4:0]  stop_after;
    logic [7:0]  sent;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sdwp_hreg_t;

  sdwp_hreg_t s_reg;
  sdwp_hreg_t s_next;

  logic tick;    // end of the current timed phase
  logic access;  // apb access phase, answer pending
  logic commit;  // apb edge at which a transfer completes

  // ==========================================================================
  // next state
  always_comb begin
    s_next = s_reg;
    tick   = (s_reg.div == ((s_reg.st == H_HOLD) ? HOLD_LAST : HALF_LAST));
    access = psel & penable & ~s_reg.pready;
    commit = psel & penable & s_reg.pready;
    s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;

    // frame sequencer; data moves on rising sclk, device samples falling
    unique case (s_reg.st)
      H_IDLE: begin
        s_next.div    = 8'h00;
        s_next.sclk   = 1'b0;
        s_next.sync_n = 1'b0;
        s_next.din    = 1'b0;
      end
      H_LEAD: begin
        if (tick) begin
          s_next.sclk = 1'b1;
          s_next.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          s_next.sclk = 1'b0;
          s_next.bits = s_reg.bits + 5'h01;
          s_next.st   = H_LOW;
        end
      end
      H_LOW: begin
        if (tick) begin
          if ((s_reg.bits == sdwp_pkg::FULL_CNT) ||
              ((s_reg.stop_after != 5'h00) && (s_reg.bits == s_reg.stop_after))) begin
            s_next.sync_n = 1'b1;
            s_next.st     = H_HOLD;
          end else if (s_reg.byte_mode && (s_reg.bits == sdwp_pkg::BYTE_CNT)) begin
            s_next.st = H_GAP;
          end else begin
            s_next.sclk  = 1'b1;
            s_next.din   = s_reg.shreg[14];
            s_next.shreg = {s_reg.shreg[14:0], 1'b0};
            s_next.st    = H_HIGH;
          end
        end
      end
      H_GAP: begin
        // frame select stays low between the two bytes
        if (tick) begin
          s_next.sclk  = 1'b1;
          s_next.din   = s_reg.shreg[14];
          s_next.shreg = {s_reg.shreg[14:0], 1'b0};
          s_next.st    = H_HIGH;
        end
      end
      H_HOLD: begin
        if (tick) begin
          s_next.sync_n = 1'b0;
          s_next.din    = 1'b0;
          if (s_reg.bits == sdwp_pkg::FULL_CNT) begin
            s_next.sent = s_reg.sent + 8'h01;
          end
          s_next.st = H_IDLE;
        end
      end
    endcase

    // apb slave: ready one cycle into the access phase, effect at that edge
    s_next.pready  = access;
    s_next.pslverr = 1'b0;
    if (access) begin
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        sdwp_pkg::REG_TX: begin
          s_next.prdata[15:0] = s_reg.txword;
          s_next.pslverr = pwrite & (s_reg.st != H_IDLE);  // busy refuses a word
        end
        sdwp_pkg::REG_CTRL: begin
          s_next.prdata[sdwp_pkg::CTRL_BYTE_MODE] = s_reg.byte_mode;
          s_next.prdata[sdwp_pkg::CTRL_LSB_FIRST] = s_reg.lsb_first;
          s_next.prdata[sdwp_pkg::CTRL_STOP_LO+:5] = s_reg.stop_after;
        end
        sdwp_pkg::REG_STAT: begin
          s_next.prdata[0] = (s_reg.st != H_IDLE);
          s_next.prdata[sdwp_pkg::STAT_SENT_LO+:8] = s_reg.sent;
          s_next.pslverr = pwrite;
        end
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // writes land only at the edge that sees pready high, and never if refused
    if (commit && pwrite && !s_reg.pslverr) begin
      if (paddr == sdwp_pkg::REG_TX) begin
        // a word is loaded and the frame opens with its first bit on din
        s_next.txword = pwdata[15:0];
        s_next.shreg  = s_reg.lsb_first ? sdwp_pkg::bit_rev16(pwdata[15:0])
                                        : pwdata[15:0];
        s_next.din    = s_reg.lsb_first ? pwdata[0] : pwdata[15];
        s_next.sync_n = 1'b0;
        s_next.sclk   = 1'b0;
        s_next.bits   = 5'h00;
        s_next.div    = 8'h00;
        s_next.st     = H_LEAD;
      end else if (paddr == sdwp_pkg::REG_CTRL) begin
        s_next.byte_mode  = pwdata[sdwp_pkg::CTRL_BYTE_MODE];
        s_next.lsb_first  = pwdata[sdwp_pkg::CTRL_LSB_FIRST];
        s_next.stop_after = pwdata[sdwp_pkg::CTRL_STOP_LO+:5];
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: H_IDLE, div: 8'h00, bits: 5'h00, shreg: 16'h0000,
                 txword: 16'h0000, byte_mode: 1'b0, lsb_first: 1'b0,
                 stop_after: 5'h00, sent: 8'h00, sclk: 1'b0, sync_n: 1'b0,
                 din: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs straight from the state flops
  assign prdata      = s_reg.prdata;
  assign pready      = s_reg.pready;
  assign pslverr     = s_reg.pslverr;
  assign link.sclk   = s_reg.sclk;
  assign link.sync_n = s_reg.sync_n;
  assign link.din    = s_reg.din;

endmodule : sdwp_host
`default_nettype wire

// [testbench/sdwp_link_chk.sv]
// assertion checker for the serial write link and the converter outputs
`default_nettype none
module sdwp_link_chk (
  input wire logic        pclk,     // system clock
  input wire logic        presetn,  // async reset, active low
  input wire logic        sclk,     // serial clock
  input wire logic        sync_n,   // frame select, active low
  input wire logic        din,      // serial data
  input wire logic [11:0] dac_code, // converter register
  input wire logic [1:0]  op_mode,  // operating mode
  input wire logic        amp_on,   // amplifier driving
  input wire logic        pd_5k,    // 5k pull-down
  input wire logic        pd_100k,  // 100k pull-down
  input wire logic        out_hiz,  // output floating
  input wire logic        update,   // word applied
  input wire logic        aborted   // frame discarded
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // converter side
  AST_FLAGS: assert property ({amp_on, pd_5k, pd_100k, out_hiz} == (4'h8 >> op_mode))
    else $error("output stage flags disagree with mode");
  AST_HOLD: assert property (($changed(dac_code) || $changed(op_mode)) |-> update)
    else $error("code or mode changed without a completed word");
  AST_UPD_PULSE: assert property (update |=> !update)
    else $error("update lasted more than one cycle");
  // update comes 3..4 cycles after the last falling edge, clock low since
  AST_UPD_TIME: assert property (update |-> !$past(sclk, 1) && !$past(sclk, 3)
    && ($past(sclk, 4) || $past(sclk, 5)))
    else $error("update not tied to a falling serial clock edge");
  AST_ABT_CAUSE: assert property (aborted |-> $past(sync_n, 2) || $past(sync_n, 3))
    else $error("abort without a frame select rise");
  AST_EXCL: assert property (!(update && aborted))
    else $error("update and abort together");

  // ==========================================================================
  // host side of the wire
  AST_SCLK_IDLE: assert property (sync_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_SYNC_HIGH: assert property ($rose(sync_n) |-> sync_n [*4])
    else $error("frame select high time too short");
  AST_DIN_STABLE: assert property ($fell(sclk) |-> $stable(din))
    else $error("data changed on the sampling edge");

  // main scenarios reached
  cover property (update && op_mode == 2'h3);
  cover property (update && op_mode == 2'h0 && $past(out_hiz));
  cover property (aborted);
endmodule : sdwp_link_chk
`default_nettype wire

// [testbench/test_serial_dac_write_port.sv]
// self-checking bench: apb host and converter joined over the serial link
`default_nettype none
module test_serial_dac_write_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, update, aborted, amp_on, pd_5k, pd_100k, out_hiz;
  logic [11:0] dac_code, exp_code;
  logic [1:0]  op_mode, exp_mode;
  logic [7:0]  sent;
  logic [31:0] seed, rd;
  logic [15:0] w, c;
  logic        er;
  int          err_count, tests_run;
  logic [15:0] corner [3] = '{16'hCFFF, 16'h3000, 16'h0800};

  sdwp_link_if link ();
  sdwp_host #(.HALF_CYCLES(4)) u_sdwp_host (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
  sdwp_device u_sdwp_device (.pclk, .presetn, .link(link), .dac_code, .op_mode, .amp_on,
    .pd_5k, .pd_100k, .out_hiz, .update, .aborted);
  sdwp_link_chk u_chk (.pclk, .presetn, .sclk(link.sclk), .sync_n(link.sync_n),
    .din(link.din), .dac_code, .op_mode, .amp_on, .pd_5k, .pd_100k, .out_hiz, .update,
    .aborted);

  // ==========================================================================
  // clock and helpers
  always #20 pclk = ~pclk;

  // xorshift keeps the run repeatable
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd

  // word as it must arrive on the wire, msb first
  function automatic logic [15:0] wire_word(input logic [15:0] wd, input logic lsb);
    logic [15:0] r;
    r = wd;
    if (lsb) begin
      for (int i = 0; i < 16; i++) begin
        r[i] = wd[15 - i];
      end
    end
    return r;
  endfunction : wire_word

  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) begin
      err_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check_out();
    chk(dac_code, exp_code);
    chk(op_mode, exp_mode);
    chk({amp_on, pd_5k, pd_100k, out_hiz}, 4'h8 >> exp_mode);
  endtask : check_out

  // send one word with the given framing options; ok says whether it must land
  task automatic xfer(input logic [15:0] wd, input logic [12:0] ctrl, input logic ok);
    logic [15:0] ww;
    int n;
    ww = wire_word(wd, ctrl[1]);
    apb(1'b1, sdwp_pkg::REG_CTRL, {19'h0, ctrl});
    apb(1'b1, sdwp_pkg::REG_TX, {16'h0, wd});
    chk(er, 1'b0);
    apb(1'b1, sdwp_pkg::REG_TX, {16'h0, ~wd});
    chk(er, 1'b1);
    for (n = 0; n < 400 && update !== 1'b1 && aborted !== 1'b1; n++) @(negedge pclk);
    if (n == 400) begin
      err_count++;
      results();
    end
    chk(update, ok);
    chk(aborted, !ok);
    if (ok) begin
      exp_code = ww[11:0];
      exp_mode = ww[13:12];
      sent++;
    end
    check_out();
    // poll busy; the refused write above must not disturb the word
    for (n = 0; n < 50; n++) begin
      apb(1'b0, sdwp_pkg::REG_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 50) begin
      err_count++;
      results();
    end
    chk(rd[15:8], sent);
    apb(1'b0, sdwp_pkg::REG_TX, 32'h0);
    chk(rd[15:0], wd);
  endtask : xfer

  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h0000_C98F;  // 51599
    exp_code = 12'h000;
    exp_mode = 2'h0;
    sent = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check_out();
    repeat (4) @(posedge pclk);
    // every power-down mode, then back to normal
    for (int m = 1; m < 5; m++) begin
      w = rnd();
      w[13:12] = m[1:0];
      xfer(w, 13'h0000, 1'b1);
    end
    foreach (corner[i]) xfer(corner[i], 13'h0000, 1'b1);
    xfer(rnd(), 13'h0100, 1'b0);
    xfer(rnd(), 13'h0F00, 1'b0);
    apb(1'b0, sdwp_pkg::REG_CTRL, 32'h0);
    chk(rd[12:0], 13'h0F00);
    xfer(rnd(), 13'h0001, 1'b1);
    xfer(rnd(), 13'h0002, 1'b1);
    for (int i = 0; i < 6; i++) begin
      c = rnd();
      xfer(rnd(), {11'h0, c[1:0]}, 1'b1);
    end
    // reset again in mid-run: power-on values must come back
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    exp_code = sdwp_pkg::CODE_RESET;
    exp_mode = sdwp_pkg::MODE_RESET;
    sent = 8'h00;
    @(negedge pclk);
    check_out();
    repeat (4) @(posedge pclk);
    xfer(rnd(), 13'h0000, 1'b1);
    // refused accesses
    apb(1'b1, sdwp_pkg::REG_STAT, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    check_out();
    results();
  end
endmodule : test_serial_dac_write_port
`default_nettype wire
